// File: hw/cdcsn_defines.vh
// constants for the serial-state notifier block
`ifndef CDCSN_DEFINES_VH
`define CDCSN_DEFINES_VH
`define CDCSN_NOTIFY_CODE 8'h20
`define CDCSN_REQ_TYPE 8'ha1
`define CDCSN_NOTIFY_LEN 16'h0002
`define CDCSN_NOTIFY_VALUE 16'h0000
`define CDCSN_NOTIFY_INDEX 16'h0000
`define CDCSN_BIT_OVERRUN 6
`define CDCSN_BIT_PARITY 5
`define CDCSN_BIT_FRAMING 4
`define CDCSN_EP_BULK_IN 4'h1
`define CDCSN_EP_BULK_OUT 4'h2
`define CDCSN_PIPE_BULK_MIN 4'h1
`define CDCSN_PIPE_BULK_MAX 4'h5
`define CDCSN_PIPE_INT_MIN 4'h6
`define CDCSN_PIPE_INT_MAX 4'h9
`define CDCSN_LC_LEN 4'h7
`define CDCSN_ADDR_CTRL 12'h000
`define CDCSN_ADDR_STATUS 12'h004
`define CDCSN_ADDR_PIPES 12'h008
`define CDCSN_ADDR_LC_RATE 12'h00c
`define CDCSN_ADDR_LC_FMT 12'h010
`define CDCSN_ADDR_EPS 12'h014
`define CDCSN_RST_PIPES 12'h612
`define CDCSN_RST_RATE 32'h00002580
`define CDCSN_RST_FMT 24'h080000
`define CDCSN_RST_ENABLE 1'b0
`define CDCSN_RST_BULK_OUT_PIPE 4'h2
`define CDCSN_RST_BULK_IN_PIPE 4'h1
`define CDCSN_RST_INT_PIPE 4'h6
`define CDCSN_RST_STOP 8'h00
`define CDCSN_RST_PARITY 8'h00
`define CDCSN_RST_DATA_BITS 8'h08
`endif

// File: hw/cdcsn_top.v
// serial-state notifier, bulk pipe and endpoint assignment and apb registers for a cdc acm function
//Operation
//RL1: only serial-state notifications, code 0x20, are ever sent
//RL2: notify once on entering error; no repeats while error persists
//RL3: overrun, parity and framing errors are the watched conditions
//RL4: value and index zero, length two, two-byte bitmap payload
//RL5: bitmap bit 6 overrun, bit 5 parity, bit 4 framing
//RL6: bits 15..7 reserved; bits 3..1 stay cleared
//RL7: host data in on bulk out ep2, device data out on bulk in ep1
//RL8: host completes a transfer only on a short packet
//RL9: bulk pipes lie in 1..5 and never share a pipe
//RL10: interrupt in pipe lies in 6..9
//RL11: host reads line coding and sets control lines before use
//RL12: line coding is 4-byte rate then stop, parity, data bytes
//RL13: one notification per transfer; next queued only after host takes it
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "cdcsn_defines.vh"
module cdcsn_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire err_overrun,
   input wire err_parity,
   input wire err_framing,
   output reg notify_valid,
   output reg [63:0] notify_setup,
   output reg [15:0] notify_bitmap,
   input wire notify_taken,
   output reg [3:0] int_pipe,
   output reg [3:0] bulk_in_pipe,
   output reg [3:0] bulk_out_pipe,
   output reg [3:0] bulk_in_ep,
   output reg [3:0] bulk_out_ep,
   output reg [31:0] lc_rate,
   output reg [7:0] lc_stop,
   output reg [7:0] lc_parity,
   output reg [7:0] lc_data_bits
);
   // idle waits for an error edge; send holds one notification until the host takes it
   localparam ST_IDLE = 2'b01;
   localparam ST_SEND = 2'b10;

   // pipe assignment is legal when bulk pipes differ and all lie in range
   function pipes_ok;
      input [3:0] pin;
      input [3:0] pout;
      input [3:0] pint;
      begin
         pipes_ok = (pin >= `CDCSN_PIPE_BULK_MIN) && (pin <= `CDCSN_PIPE_BULK_MAX) && // RL9
            (pout >= `CDCSN_PIPE_BULK_MIN) && (pout <= `CDCSN_PIPE_BULK_MAX) &&
            (pin != pout) &&
            (pint >= `CDCSN_PIPE_INT_MIN) && (pint <= `CDCSN_PIPE_INT_MAX); // RL10
      end
   endfunction

   // true for the six mapped register offsets
   function addr_mapped;
      input [11:0] a;
      begin
         addr_mapped = (a == `CDCSN_ADDR_CTRL) || (a == `CDCSN_ADDR_STATUS) ||
            (a == `CDCSN_ADDR_PIPES) || (a == `CDCSN_ADDR_LC_RATE) ||
            (a == `CDCSN_ADDR_LC_FMT) || (a == `CDCSN_ADDR_EPS);
      end
   endfunction

   // line-state word from the error edges; every bit outside 6..4 stays clear
   function [15:0] bitmap_of;
      input [2:0] edges;
      begin
         bitmap_of = 16'h0000; // RL6
         bitmap_of[`CDCSN_BIT_OVERRUN] = edges[2]; // RL5
         bitmap_of[`CDCSN_BIT_PARITY] = edges[1];
         bitmap_of[`CDCSN_BIT_FRAMING] = edges[0];
      end
   endfunction

   reg [2:0] err_meta;
   reg [2:0] err_sync;
   reg [2:0] err_prev;
   reg [2:0] err_pend;
   reg [1:0] state;
   reg notify_enable;
   // wraps silently; software sees only the low 24 bits
   reg [31:0] notify_count;
   wire [2:0] err_rise;
   wire apb_wr;
   wire apb_rd;
   wire addr_ok;
   wire pipe_wr_ok;

   // zero wait states: every register answers in its first access cycle
   assign pready = 1'b1;
   assign apb_wr = psel & penable & pwrite;
   // reads decode in setup so prdata already stands when pready is sampled
   assign apb_rd = psel & ~penable & ~pwrite;
   assign addr_ok = addr_mapped(paddr);
   assign pipe_wr_ok = pipes_ok(pwdata[7:4], pwdata[3:0], pwdata[11:8]);
   // a bad address or an illegal pipe write is answered with an error
   assign pslverr = psel & penable & (~addr_ok |
      (pwrite & (paddr == `CDCSN_ADDR_PIPES) & ~pipe_wr_ok));

   // error lines come from the uart clock domain
   // only err_sync reads err_meta, so a metastable value cannot spread
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_meta <= 3'b000;
         err_sync <= 3'b000;
      end else begin
         err_meta <= {err_overrun, err_parity, err_framing}; // RL3
         err_sync <= err_meta;
      end
   end

   // only a rise counts, so a persisting error never repeats a notification
   assign err_rise = err_sync & ~err_prev; // RL2

   // edges gather while a notification is in flight so none is lost
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_prev <= 3'b000;
         err_pend <= 3'b000;
         state <= ST_IDLE;
         notify_valid <= 1'b0;
         notify_bitmap <= 16'h0000;
         notify_setup <= 64'h0;
         notify_count <= 32'h0;
      end else begin
         err_prev <= err_sync;
         case (state)
            ST_IDLE: begin
               if (notify_enable && ((err_pend | err_rise) != 3'b000)) begin
                  notify_valid <= 1'b1;
                  notify_bitmap <= bitmap_of(err_pend | err_rise); // RL5 RL6
                  // request type, code, value, index, length in wire order
                  notify_setup <= {`CDCSN_NOTIFY_LEN, `CDCSN_NOTIFY_INDEX,
                     `CDCSN_NOTIFY_VALUE, `CDCSN_NOTIFY_CODE, `CDCSN_REQ_TYPE}; // RL1 RL4
                  err_pend <= 3'b000;
                  state <= ST_SEND;
               end else if (!notify_enable) begin
                  // edges seen while disabled are dropped, never replayed later
                  err_pend <= 3'b000;
               end
            end
            ST_SEND: begin
               err_pend <= err_pend | err_rise; // RL13
               if (notify_taken) begin
                  notify_valid <= 1'b0; // RL13
                  notify_count <= notify_count + 32'h1;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
               notify_valid <= 1'b0;
            end
         endcase
      end
   end

   // register writes take effect in the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         notify_enable <= `CDCSN_RST_ENABLE;
         // reset pipes form a legal set; refused writes keep it legal
         bulk_out_pipe <= `CDCSN_RST_BULK_OUT_PIPE;
         bulk_in_pipe <= `CDCSN_RST_BULK_IN_PIPE;
         int_pipe <= `CDCSN_RST_INT_PIPE;
         bulk_in_ep <= `CDCSN_EP_BULK_IN; // RL7
         bulk_out_ep <= `CDCSN_EP_BULK_OUT; // RL7
         lc_rate <= `CDCSN_RST_RATE;
         lc_stop <= `CDCSN_RST_STOP;
         lc_parity <= `CDCSN_RST_PARITY;
         lc_data_bits <= `CDCSN_RST_DATA_BITS;
      end else if (apb_wr) begin
         case (paddr)
            `CDCSN_ADDR_CTRL: notify_enable <= pwdata[0];
            `CDCSN_ADDR_PIPES: begin
               if (pipe_wr_ok) begin // RL9 RL10
                  bulk_out_pipe <= pwdata[3:0];
                  bulk_in_pipe <= pwdata[7:4];
                  int_pipe <= pwdata[11:8];
               end
            end
            // line coding is only stored here; the uart takes it as it stands
            `CDCSN_ADDR_LC_RATE: lc_rate <= pwdata; // RL12
            `CDCSN_ADDR_LC_FMT: begin
               lc_stop <= pwdata[7:0]; // RL12
               lc_parity <= pwdata[15:8];
               lc_data_bits <= pwdata[23:16];
            end
            default: begin
               // read-only and unmapped offsets ignore writes
            end
         endcase
      end
   end

   // read data is latched in the setup phase and stands through access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (apb_rd) begin
         case (paddr)
            `CDCSN_ADDR_CTRL: prdata <= {31'h0, notify_enable};
            // count, sending flag, pending edges and synchronised error levels
            `CDCSN_ADDR_STATUS: prdata <= {notify_count[23:0], 1'b0, state[1],
               err_pend, err_sync};
            `CDCSN_ADDR_PIPES: prdata <= {20'h0, int_pipe, bulk_in_pipe, bulk_out_pipe};
            `CDCSN_ADDR_LC_RATE: prdata <= lc_rate;
            `CDCSN_ADDR_LC_FMT: prdata <= {8'h0, lc_data_bits, lc_parity, lc_stop};
            `CDCSN_ADDR_EPS: prdata <= {24'h0, bulk_in_ep, bulk_out_ep};
            default: prdata <= 32'h0;
         endcase
      end
   end
endmodule

// File: verification/cdcsn_asserts.sv
// port checker for the serial-state notifier
`timescale 1ns/100ps
module cdcsn_asserts (
   input logic pclk,
   input logic presetn,
   input logic pready,
   input logic notify_valid,
   input logic notify_taken,
   input logic [63:0] notify_setup,
   input logic [15:0] notify_bitmap,
   input logic [3:0] int_pipe,
   input logic [3:0] bulk_in_pipe,
   input logic [3:0] bulk_out_pipe,
   input logic [3:0] bulk_in_ep,
   input logic [3:0] bulk_out_ep
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_SETUP: assert property (notify_valid |-> notify_setup == 64'h0002_0000_0000_20a1)
      else $error("setup packet wrong");
   AST_RSVD: assert property (notify_valid |-> notify_bitmap[15:7] == 0 && notify_bitmap[3:0] == 0)
      else $error("reserved bitmap bits set");
   AST_CAUSE: assert property ($rose(notify_valid) |-> notify_bitmap[6:4] != 0)
      else $error("notification without error bit");
   AST_HOLD: assert property (notify_valid && !notify_taken |=> notify_valid && $stable(notify_bitmap))
      else $error("notification dropped before take");
   AST_TAKE: assert property (notify_valid && notify_taken |=> !notify_valid)
      else $error("notification kept after take");
   AST_BULK: assert property (bulk_in_pipe != bulk_out_pipe && bulk_in_pipe inside {[1:5]}
      && bulk_out_pipe inside {[1:5]}) else $error("bulk pipe illegal");
   AST_INT: assert property (int_pipe inside {[6:9]})
      else $error("interrupt pipe illegal");
   AST_EPS: assert property (bulk_in_ep == 4'h1 && bulk_out_ep == 4'h2)
      else $error("endpoint numbers wrong");
   AST_READY: assert property (pready)
      else $error("pready low");
   cover property ($rose(notify_valid));
   cover property (notify_valid && notify_taken);
   cover property (notify_valid && notify_bitmap[6]);
   cover property (notify_valid && notify_bitmap[6] && notify_bitmap[5]);
endmodule
bind cdcsn_top cdcsn_asserts u_chk (
   .pclk(pclk),
   .presetn(presetn),
   .pready(pready),
   .notify_valid(notify_valid),
   .notify_taken(notify_taken),
   .notify_setup(notify_setup),
   .notify_bitmap(notify_bitmap),
   .int_pipe(int_pipe),
   .bulk_in_pipe(bulk_in_pipe),
   .bulk_out_pipe(bulk_out_pipe),
   .bulk_in_ep(bulk_in_ep),
   .bulk_out_ep(bulk_out_ep)
);

// File: verification/cdcsn_host.sv
// host side that takes interrupt transfers after a random stall
`timescale 1ns/100ps
module cdcsn_host (
   input logic pclk,
   input logic presetn,
   input logic notify_valid,
   output logic notify_taken
);
   int w;
   // a slow host must not cost the device an edge, so stalls vary
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         notify_taken <= 0;
         w <= 0;
      end else begin
         notify_taken <= 0;
         if (notify_valid && !notify_taken) begin
            if (w == 0) begin
               // the two-byte payload is a short packet, so the transfer ends here
               notify_taken <= 1;
               w <= $urandom % 4;
            end else begin
               w <= w - 1;
            end
         end
      end
   end
endmodule

// File: verification/cdcsn_top_tb.sv
// testbench for the serial-state notifier
`timescale 1ns/100ps
module cdcsn_top_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic err_overrun = 0, err_parity = 0, err_framing = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, lc_rate, v;
   logic pready, pslverr, notify_valid, notify_taken;
   logic [63:0] notify_setup;
   logic [15:0] notify_bitmap;
   logic [3:0] int_pipe, bulk_in_pipe, bulk_out_pipe, bulk_in_ep, bulk_out_ep;
   logic [7:0] lc_stop, lc_parity, lc_data_bits;
   logic [15:0] q[$];
   int mismatches = 0, checks_done = 0;
   always #2.5 pclk = ~pclk;
   cdcsn_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .err_overrun(err_overrun),
      .err_parity(err_parity), .err_framing(err_framing), .notify_valid(notify_valid),
      .notify_setup(notify_setup), .notify_bitmap(notify_bitmap),
      .notify_taken(notify_taken), .int_pipe(int_pipe), .bulk_in_pipe(bulk_in_pipe),
      .bulk_out_pipe(bulk_out_pipe), .bulk_in_ep(bulk_in_ep), .bulk_out_ep(bulk_out_ep),
      .lc_rate(lc_rate), .lc_stop(lc_stop), .lc_parity(lc_parity),
      .lc_data_bits(lc_data_bits));
   cdcsn_host u_host (.pclk(pclk), .presetn(presetn), .notify_valid(notify_valid),
      .notify_taken(notify_taken));
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask
   // for reads d is the expected word
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic se);
      int n;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         mismatches++;
         close_out;
      end
      if (!w)
         chk("prdata", d, prdata);
      chk("pslverr", se, pslverr);
      psel <= 0;
      penable <= 0;
   endtask
   initial begin
      void'($urandom(73273));
      repeat (5) @(posedge pclk);
      presetn <= 1;
      apb(0, 12'h00c, 32'h0000_2580, 0);
      apb(0, 12'h010, 32'h0008_0000, 0);
      apb(0, 12'h008, 32'h0000_0612, 0);
      apb(0, 12'h014, 32'h0000_0012, 0);
      apb(1, 12'h008, 32'h0000_0633, 1);
      apb(1, 12'h008, 32'h0000_0a12, 1);
      apb(1, 12'h008, 32'h0000_0934, 0);
      apb(0, 12'h008, 32'h0000_0934, 0);
      chk("pipes", 32'h0000_0934, {int_pipe, bulk_in_pipe, bulk_out_pipe});
      apb(0, 12'h100, 32'h0, 1);
      v = $urandom;
      apb(1, 12'h00c, v, 0);
      apb(0, 12'h00c, v, 0);
      chk("lc_rate", v, lc_rate);
      apb(1, 12'h010, 32'h0007_0201, 0);
      apb(0, 12'h010, 32'h0007_0201, 0);
      chk("lc_fmt", 32'h0007_0201, {8'h0, lc_data_bits, lc_parity, lc_stop});
      $display("test registers done");
      // an error while disabled must not be reported later
      err_framing <= 1;
      repeat (10) @(posedge pclk);
      err_framing <= 0;
      repeat (5) @(posedge pclk);
      apb(1, 12'h000, 32'h1, 0);
      apb(0, 12'h000, 32'h1, 0);
      for (int i = 0; i < 3; i++) begin
         q.push_back(16'h0010 << i);
         {err_overrun, err_parity, err_framing} <= 3'b001 << i;
         // held long enough that a repeat would surely show
         repeat (30) @(posedge pclk);
         {err_overrun, err_parity, err_framing} <= 3'b000;
         repeat (10) @(posedge pclk);
      end
      // parity rises while the framing notice is still offered: it must follow alone
      q.push_back(16'h0010);
      q.push_back(16'h0020);
      err_framing <= 1;
      repeat (2) @(posedge pclk);
      err_parity <= 1;
      repeat (30) @(posedge pclk);
      {err_overrun, err_parity, err_framing} <= 3'b000;
      repeat (10) @(posedge pclk);
      q.push_back(16'h0060);
      {err_overrun, err_parity, err_framing} <= 3'b110;
      repeat (30) @(posedge pclk);
      {err_overrun, err_parity, err_framing} <= 3'b000;
      repeat (10) @(posedge pclk);
      chk("queue", 32'h0, q.size());
      apb(0, 12'h004, 32'h0000_0600, 0);
      $display("test notify done");
      close_out;
   end
   always @(posedge pclk) begin
      if (notify_valid === 1'b1 && notify_taken === 1'b1) begin
         if (q.size() == 0)
            chk("extra notify", 32'h0, 32'h1);
         else
            chk("bitmap", q.pop_front(), notify_bitmap);
      end
   end
endmodule
